/* File: include/scr_pkg.sv */
// Package for the synthesizer control word register bank.
// Assumes one core clock; serial pins arrive already synchronous to it.
package scr_pkg;

  // Word layout
  localparam int WORD_W = 32;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 4;

  // Register addresses in the low four bits of a word
  localparam logic [3:0] ADDR_R0 = 4'h0;
  localparam logic [3:0] ADDR_R1 = 4'h1;
  localparam logic [3:0] ADDR_R2 = 4'h2;
  localparam logic [3:0] ADDR_R3 = 4'h3;
  localparam logic [3:0] ADDR_R4 = 4'h4;
  localparam logic [3:0] ADDR_R5 = 4'h5;
  localparam logic [3:0] ADDR_R6 = 4'h6;

  // Register 0 fields
  localparam int BAND_CAL_BIT = 21;
  localparam int PRESCALER_BIT = 20;
  localparam int INT_LSB = 4;
  localparam int INT_W = 16;

  // Register 1 fields
  localparam int FRAC_LSB = 4;
  localparam int FRAC_W = 24;

  // Register 2 fields
  localparam int AUX_NUM_LSB = 18;
  localparam int AUX_DEN_LSB = 4;
  localparam int AUX_W = 14;

  // Register 3 fields
  localparam int MOD_RST_INHIBIT_BIT = 30;
  localparam int RESYNC_EN_BIT = 29;
  localparam int PHASE_STEP_BIT = 28;
  localparam int PHASE_LSB = 4;
  localparam int PHASE_W = 24;

  // Register 4 fields
  localparam int MON_SEL_LSB = 27;
  localparam int MON_SEL_W = 3;
  localparam int REF_DOUBLER_BIT = 26;
  localparam int REF_HALVER_BIT = 25;
  localparam int R_COUNT_LSB = 15;
  localparam int R_COUNT_W = 10;
  localparam int DIV_BUFFER_BIT = 14;
  localparam int PUMP_CUR_LSB = 10;
  localparam int PUMP_CUR_W = 4;
  localparam int MON_LEVEL_BIT = 8;
  localparam int POLARITY_BIT = 7;
  localparam int POWER_DOWN_BIT = 6;
  localparam int PUMP_TRI_BIT = 5;
  localparam int COUNTER_RST_BIT = 4;

  // Register 6 fields
  localparam int DIV_SEL_LSB = 21;
  localparam int DIV_SEL_W = 3;

  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [2:0] DIV_SEL_RESET = 3'h0;
  localparam logic [23:0] PHASE_ACC_RESET = 24'h00_0000;

endpackage : scr_pkg

/* File: hw/scr_ref_divider.sv */
// Reference path: edge select, 10-bit divide and optional halving toggle.
// Assumes the reference input is already synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module scr_ref_divider (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ref_in,
  input wire logic doubler_en,
  input wire logic halver_en,
  input wire logic [9:0] r_count,
  input wire logic hold,
  output logic cmp_ref
);
  import scr_pkg::*;

  // ----------------------------------------
  // Divider state
  // ----------------------------------------
  logic ref_prev_reg, ref_prev_next;
  logic [9:0] cnt_reg, cnt_next;
  logic out_reg, out_next;
  logic edge_act;
  logic [9:0] last;

  always_comb begin
    ref_prev_next = ref_in;
    edge_act = 1'b0;
    if (doubler_en) begin
      edge_act = ref_in ^ ref_prev_reg;
    end else begin
      edge_act = ref_prev_reg & ~ref_in;
    end
    last = (r_count == 10'h000) ? 10'h000 : r_count - 10'h001;
    cnt_next = cnt_reg;
    out_next = halver_en ? out_reg : 1'b0;
    if (hold) begin
      cnt_next = 10'h000;
      out_next = 1'b0;
    end else if (edge_act) begin
      if (cnt_reg >= last) begin
        cnt_next = 10'h000;
        out_next = halver_en ? ~out_reg : 1'b1;
      end else begin
        cnt_next = cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_prev_reg <= 1'b0;
      cnt_reg <= 10'h000;
      out_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_prev_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign cmp_ref = out_reg;

endmodule : scr_ref_divider
`default_nettype wire

/* File: hw/scr_regs.sv */
// Control word register bank of a fractional-N synthesizer, three-wire load.
// Assumes serial pins are synchronous to core_clk and slower than it.
//
// Contract
// - Low four address bits route each word to registers zero to six.
// - Register zero write with calibration bit set starts band calibration unless counter reset or power down set.
// - Main fraction numerator taken from register one bits 27 to 4.
// - Registers one to four take effect on next register zero write.
// - Register zero write resets modulator unless inhibit bit set.
// - Resync applies only when auxiliary numerator is zero.
// - Phase step adds phase value on each register zero write.
// - Doubler off uses falling reference edge; on uses both edges.
// - Halver bit inserts toggle stage giving 50% duty.
// - 10-bit reference counter divides by 1 to 1023.
// - Buffering bit holds divider select until register zero write.
// - 4-bit pump current code sets charge pump level.
// - Level select and detector polarity bits drive their outputs.
// - Power down forces counters, pump, lock detect and outputs off.
// - Three-state bit floats pump; counter reset holds counters and band.
`timescale 1ns/1ns
`default_nettype none
module scr_regs (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_en,
  input wire logic reference_input,
  output logic [15:0] integer_divide,
  output logic prescaler_select,
  output logic [23:0] main_fraction_numerator,
  output logic [13:0] auxiliary_fraction_numerator,
  output logic [13:0] auxiliary_denominator,
  output logic [23:0] phase_value,
  output logic [23:0] phase_offset,
  output logic band_cal_start,
  output logic modulator_reset,
  output logic resync_arm,
  output logic [2:0] monitor_output_select,
  output logic monitor_level_select,
  output logic detector_polarity,
  output logic [3:0] pump_current_code,
  output logic pump_off,
  output logic counters_held,
  output logic lock_detect_clear,
  output logic outputs_enable,
  output logic [2:0] divider_select,
  output logic phase_comparator_ref,
  output logic [31:0] fixed_reserved_word
);
  import scr_pkg::*;

  // ----------------------------------------
  // Serial shift path
  // ----------------------------------------
  logic sclk_prev_reg, sclk_prev_next;
  logic le_prev_reg, le_prev_next;
  logic [31:0] shift_reg, shift_next;
  logic load_stb;
  logic [3:0] addr;

  always_comb begin
    sclk_prev_next = ser_clk;
    le_prev_next = load_en;
    shift_next = shift_reg;
    if (ser_clk && !sclk_prev_reg) begin
      shift_next = {shift_reg[30:0], ser_data};
    end
  end

  assign load_stb = load_en & ~le_prev_reg;
  assign addr = shift_reg[ADDR_LSB +: ADDR_W];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_reg <= 1'b0;
      le_prev_reg <= 1'b0;
      shift_reg <= WORD_RESET;
    end else begin
      sclk_prev_reg <= sclk_prev_next;
      le_prev_reg <= le_prev_next;
      shift_reg <= shift_next;
    end
  end

  // ----------------------------------------
  // Word registers and double buffers
  // ----------------------------------------
  logic [31:0] r0_reg, r0_next;
  logic [31:0] stg1_reg, stg1_next, act1_reg, act1_next;
  logic [31:0] stg2_reg, stg2_next, act2_reg, act2_next;
  logic [31:0] stg3_reg, stg3_next, act3_reg, act3_next;
  logic [31:0] stg4_reg, stg4_next, act4_reg, act4_next;
  logic [31:0] r5_reg, r5_next;
  logic [2:0] div_stg_reg, div_stg_next, div_act_reg, div_act_next;
  logic [23:0] phase_acc_reg, phase_acc_next;
  logic cal_reg, cal_next;
  logic mrst_reg, mrst_next;
  logic resync_reg, resync_next;
  logic r0_write;

  assign r0_write = load_stb && (addr == ADDR_R0);

  always_comb begin
    r0_next = r0_reg;
    stg1_next = stg1_reg;
    stg2_next = stg2_reg;
    stg3_next = stg3_reg;
    stg4_next = stg4_reg;
    act1_next = act1_reg;
    act2_next = act2_reg;
    act3_next = act3_reg;
    act4_next = act4_reg;
    r5_next = r5_reg;
    div_stg_next = div_stg_reg;
    div_act_next = div_act_reg;
    phase_acc_next = phase_acc_reg;
    cal_next = 1'b0;
    mrst_next = 1'b0;
    resync_next = 1'b0;
    if (load_stb) begin
      case (addr)
        ADDR_R0: r0_next = shift_reg;
        ADDR_R1: stg1_next = shift_reg;
        ADDR_R2: stg2_next = shift_reg;
        ADDR_R3: stg3_next = shift_reg;
        ADDR_R4: stg4_next = shift_reg;
        ADDR_R5: r5_next = shift_reg;
        ADDR_R6: begin
          if (act4_reg[DIV_BUFFER_BIT]) begin
            div_stg_next = shift_reg[DIV_SEL_LSB +: DIV_SEL_W];
          end else begin
            div_act_next = shift_reg[DIV_SEL_LSB +: DIV_SEL_W];
            div_stg_next = shift_reg[DIV_SEL_LSB +: DIV_SEL_W];
          end
        end
        default: begin
          r0_next = r0_reg;
        end
      endcase
    end
    if (r0_write) begin
      act1_next = stg1_reg;
      act2_next = stg2_reg;
      act3_next = stg3_reg;
      act4_next = stg4_reg;
      if (act4_reg[DIV_BUFFER_BIT]) begin
        div_act_next = div_stg_reg;
      end
      if (!stg4_reg[COUNTER_RST_BIT] && !stg4_reg[POWER_DOWN_BIT]) begin
        cal_next = shift_reg[BAND_CAL_BIT];
      end
      mrst_next = ~stg3_reg[MOD_RST_INHIBIT_BIT];
      resync_next = stg3_reg[RESYNC_EN_BIT] &&
                    (stg2_reg[AUX_NUM_LSB +: AUX_W] == 14'h0000);
      if (stg3_reg[PHASE_STEP_BIT]) begin
        phase_acc_next = phase_acc_reg + stg3_reg[PHASE_LSB +: PHASE_W];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      r0_reg <= WORD_RESET;
      stg1_reg <= WORD_RESET;
      stg2_reg <= WORD_RESET;
      stg3_reg <= WORD_RESET;
      stg4_reg <= WORD_RESET;
      act1_reg <= WORD_RESET;
      act2_reg <= WORD_RESET;
      act3_reg <= WORD_RESET;
      act4_reg <= WORD_RESET;
      r5_reg <= WORD_RESET;
      div_stg_reg <= DIV_SEL_RESET;
      div_act_reg <= DIV_SEL_RESET;
      phase_acc_reg <= PHASE_ACC_RESET;
      cal_reg <= 1'b0;
      mrst_reg <= 1'b0;
      resync_reg <= 1'b0;
    end else begin
      r0_reg <= r0_next;
      stg1_reg <= stg1_next;
      stg2_reg <= stg2_next;
      stg3_reg <= stg3_next;
      stg4_reg <= stg4_next;
      act1_reg <= act1_next;
      act2_reg <= act2_next;
      act3_reg <= act3_next;
      act4_reg <= act4_next;
      r5_reg <= r5_next;
      div_stg_reg <= div_stg_next;
      div_act_reg <= div_act_next;
      phase_acc_reg <= phase_acc_next;
      cal_reg <= cal_next;
      mrst_reg <= mrst_next;
      resync_reg <= resync_next;
    end
  end

  // ----------------------------------------
  // Derived control outputs
  // ----------------------------------------
  logic pump_off_reg, pump_off_next;
  logic held_reg, held_next;
  logic ld_clr_reg, ld_clr_next;
  logic oen_reg, oen_next;

  always_comb begin
    pump_off_next = act4_reg[PUMP_TRI_BIT] | act4_reg[POWER_DOWN_BIT];
    held_next = act4_reg[COUNTER_RST_BIT] | act4_reg[POWER_DOWN_BIT];
    ld_clr_next = act4_reg[POWER_DOWN_BIT];
    oen_next = ~act4_reg[POWER_DOWN_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pump_off_reg <= 1'b0;
      held_reg <= 1'b0;
      ld_clr_reg <= 1'b0;
      oen_reg <= 1'b0;
    end else begin
      pump_off_reg <= pump_off_next;
      held_reg <= held_next;
      ld_clr_reg <= ld_clr_next;
      oen_reg <= oen_next;
    end
  end

  // ----------------------------------------
  // Reference path
  // ----------------------------------------
  scr_ref_divider u_ref_div (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ref_in(reference_input),
    .doubler_en(act4_reg[REF_DOUBLER_BIT]),
    .halver_en(act4_reg[REF_HALVER_BIT]),
    .r_count(act4_reg[R_COUNT_LSB +: R_COUNT_W]),
    .hold(held_reg),
    .cmp_ref(phase_comparator_ref)
  );

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  assign integer_divide = r0_reg[INT_LSB +: INT_W];
  assign prescaler_select = r0_reg[PRESCALER_BIT];
  assign main_fraction_numerator = act1_reg[FRAC_LSB +: FRAC_W];
  assign auxiliary_fraction_numerator = act2_reg[AUX_NUM_LSB +: AUX_W];
  assign auxiliary_denominator = act2_reg[AUX_DEN_LSB +: AUX_W];
  assign phase_value = act3_reg[PHASE_LSB +: PHASE_W];
  assign phase_offset = phase_acc_reg;
  assign band_cal_start = cal_reg;
  assign modulator_reset = mrst_reg;
  assign resync_arm = resync_reg;
  assign monitor_output_select = act4_reg[MON_SEL_LSB +: MON_SEL_W];
  assign monitor_level_select = act4_reg[MON_LEVEL_BIT];
  assign detector_polarity = act4_reg[POLARITY_BIT];
  assign pump_current_code = act4_reg[PUMP_CUR_LSB +: PUMP_CUR_W];
  assign pump_off = pump_off_reg;
  assign counters_held = held_reg;
  assign lock_detect_clear = ld_clr_reg;
  assign outputs_enable = oen_reg;
  assign divider_select = div_act_reg;
  assign fixed_reserved_word = r5_reg;

endmodule : scr_regs
`default_nettype wire

/* File: dv/scr_host_model.sv */
// Host model: shifts control words into the register bank over three wires.
// Assumes the bench calls send_word only after reset is released.
`timescale 1ns/1ns
`default_nettype none
module scr_host_model (
  input wire logic core_clk,
  output logic ser_clk,
  output logic ser_data,
  output logic load_en
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_en = 1'b0;
  end
  // ----------------
  // Word transfer
  // ----------------
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge core_clk);
      ser_clk <= 1'b0;
      ser_data <= w[i];
      @(posedge core_clk);
      ser_clk <= 1'b1;
    end
    @(posedge core_clk);
    ser_clk <= 1'b0;
    load_en <= 1'b1;
    ser_data <= ~w[0];
    repeat (3) @(posedge core_clk);
    load_en <= 1'b0;
    @(posedge core_clk);
  endtask : send_word
endmodule : scr_host_model
`default_nettype wire

/* File: dv/scr_regs_asserts.sv */
// Checker for the control word register bank, bound to scr_regs.
// Assumes serial pins are sampled on core_clk as the design does.
`timescale 1ns/1ns
`default_nettype none
module scr_regs_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_en,
  input wire logic [15:0] integer_divide,
  input wire logic prescaler_select,
  input wire logic [23:0] main_fraction_numerator,
  input wire logic [13:0] auxiliary_fraction_numerator,
  input wire logic [23:0] phase_offset,
  input wire logic band_cal_start,
  input wire logic modulator_reset,
  input wire logic resync_arm,
  input wire logic pump_off,
  input wire logic counters_held,
  input wire logic lock_detect_clear,
  input wire logic outputs_enable,
  input wire logic phase_comparator_ref,
  input wire logic [31:0] fixed_reserved_word
);
  // ----------------
  // Shadow shifter
  // ----------------
  logic [31:0] sh_reg;
  logic [31:0] sh_next;
  logic sclk_reg;
  logic ld_reg;
  logic ld_rise;
  always_comb begin
    sh_next = (ser_clk && !sclk_reg) ? {sh_reg[30:0], ser_data} : sh_reg;
  end
  assign ld_rise = load_en && !ld_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_reg <= 32'h0000_0000;
      sclk_reg <= 1'b0;
      ld_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      sclk_reg <= ser_clk;
      ld_reg <= load_en;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_route_reg0: assert property (ld_rise && sh_reg[3:0] == 4'h0 |-> ##2
    integer_divide == $past(sh_reg[19:4], 2) && prescaler_select == $past(sh_reg[20], 2)) else $error("reg0 fields");
  chk_route_reg5: assert property (ld_rise && sh_reg[3:0] == 4'h5 |-> ##2
    fixed_reserved_word == $past(sh_reg, 2)) else $error("reg5 word");
  chk_frac_commit: assert property ($changed(main_fraction_numerator) |->
    $past(ld_rise) && $past(sh_reg[3:0]) == 4'h0) else $error("fraction moved early");
  chk_cal_cause: assert property (band_cal_start |->
    $past(ld_rise) && $past(sh_reg[21]) && $past(sh_reg[3:0]) == 4'h0) else $error("stray calibration");
  chk_modrst_cause: assert property (modulator_reset |->
    $past(ld_rise) && $past(sh_reg[3:0]) == 4'h0) else $error("stray modulator reset");
  chk_pulse_width: assert property (band_cal_start || modulator_reset || resync_arm |=>
    !band_cal_start && !modulator_reset && !resync_arm) else $error("pulse too long");
  chk_resync_aux: assert property (resync_arm |-> auxiliary_fraction_numerator == 14'h0) else $error("resync");
  chk_phase_moment: assert property ($changed(phase_offset) |->
    $past(ld_rise) && $past(sh_reg[3:0]) == 4'h0) else $error("phase moved");
  chk_power_down: assert property (lock_detect_clear |-> !outputs_enable && pump_off && counters_held)
    else $error("power down incomplete");
  chk_ref_held: assert property (counters_held [*3] |-> !phase_comparator_ref) else $error("ref not held");
endmodule : scr_regs_asserts
bind scr_regs scr_regs_asserts chk (.core_clk, .rst_b, .ser_clk, .ser_data, .load_en, .integer_divide,
  .prescaler_select, .main_fraction_numerator, .auxiliary_fraction_numerator, .phase_offset, .band_cal_start,
  .modulator_reset, .resync_arm, .pump_off, .counters_held, .lock_detect_clear, .outputs_enable,
  .phase_comparator_ref, .fixed_reserved_word);
`default_nettype wire

/* File: dv/tb.sv */
// Testbench for the control word register bank.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import scr_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reference_input = 1'b0;
  logic ser_clk, ser_data, load_en;
  logic [15:0] integer_divide;
  logic [23:0] main_fraction_numerator, phase_value, phase_offset;
  logic [13:0] auxiliary_fraction_numerator, auxiliary_denominator;
  logic [3:0] pump_current_code;
  logic [2:0] monitor_output_select, divider_select;
  logic [31:0] fixed_reserved_word;
  logic prescaler_select, band_cal_start, modulator_reset, resync_arm, monitor_level_select;
  logic detector_polarity, pump_off, counters_held, lock_detect_clear, outputs_enable, phase_comparator_ref;
  int fails = 0;
  int check_count = 0;
  int n_cal = 0;
  int n_mr = 0;
  int n_rs = 0;
  int n_ref = 0;
  int cycles = 0;
  int m0, c0, r0;
  always #2 core_clk = ~core_clk;
  scr_regs dut (.core_clk, .rst_b, .ser_clk, .ser_data, .load_en, .reference_input, .integer_divide,
    .prescaler_select, .main_fraction_numerator, .auxiliary_fraction_numerator, .auxiliary_denominator,
    .phase_value, .phase_offset, .band_cal_start, .modulator_reset, .resync_arm, .monitor_output_select,
    .monitor_level_select, .detector_polarity, .pump_current_code, .pump_off, .counters_held,
    .lock_detect_clear, .outputs_enable, .divider_select, .phase_comparator_ref, .fixed_reserved_word);
  scr_host_model host (.core_clk, .ser_clk, .ser_data, .load_en);
  // ----------------
  // Helpers
  // ----------------
  always @(posedge core_clk) begin
    reference_input <= ~reference_input;
    n_cal += (band_cal_start === 1'b1);
    n_mr += (modulator_reset === 1'b1);
    n_rs += (resync_arm === 1'b1);
    n_ref += (phase_comparator_ref === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic w0(input logic cal, input logic pre, input logic [15:0] n);
    host.send_word({10'h0, cal, pre, n, 4'h0});
  endtask : w0
  task automatic w3(input logic inh, input logic rs, input logic st, input logic [23:0] ph);
    host.send_word({1'b0, inh, rs, st, ph, 4'h3});
  endtask : w3
  task automatic w4(input logic buf_en, input logic pd, input logic tri_en);
    host.send_word({2'h0, 3'h1, 2'h0, 10'd1, buf_en, 4'hb, 3'b011, pd, tri_en, 1'b0, 4'h4});
  endtask : w4
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_staging();
    host.send_word({4'h0, 24'h5a5a5a, 4'h1});
    check(main_fraction_numerator, 24'h0);
    host.send_word({14'h0011, 14'h0123, 4'h2});
    m0 = n_mr;
    w0(1'b0, 1'b1, 16'd100);
    check(main_fraction_numerator, 24'h5a5a5a);
    check(auxiliary_denominator, 14'h0123);
    check(auxiliary_fraction_numerator, 14'h0011);
    check(integer_divide, 16'd100);
    check(prescaler_select, 1'b1);
    check(n_mr, m0 + 1);
  endtask : t_staging
  task automatic t_phase();
    w3(1'b1, 1'b0, 1'b1, 24'h400000);
    m0 = n_mr;
    c0 = phase_offset;
    w0(1'b0, 1'b0, 16'd50);
    w0(1'b0, 1'b0, 16'd50);
    check(phase_offset, (c0 + 24'h800000) & 24'hffffff);
    check(phase_value, 24'h400000);
    check(n_mr, m0);
    w3(1'b0, 1'b1, 1'b0, 24'h0);
    r0 = n_rs;
    w0(1'b0, 1'b0, 16'd50);
    check(n_rs, r0);
    host.send_word({14'h0, 14'h0123, 4'h2});
    c0 = n_cal;
    w0(1'b1, 1'b0, 16'd50);
    check(n_rs, r0 + 1);
    check(n_cal, c0 + 1);
  endtask : t_phase
  task automatic t_power();
    c0 = n_cal;
    w4(1'b0, 1'b1, 1'b0);
    w0(1'b1, 1'b0, 16'd50);
    check({outputs_enable, lock_detect_clear, pump_off, counters_held}, 4'b0111);
    check({pump_current_code, monitor_level_select, detector_polarity}, 6'b101111);
    check(monitor_output_select, 3'h1);
    check(phase_comparator_ref, 1'b0);
    check(n_cal, c0);
    w4(1'b1, 1'b0, 1'b1);
    w0(1'b0, 1'b0, 16'd50);
    check({outputs_enable, lock_detect_clear, pump_off, counters_held}, 4'b1010);
    @(negedge core_clk);
    r0 = n_ref;
    repeat (20) @(negedge core_clk);
    check(n_ref - r0, 10);
  endtask : t_power
  task automatic t_misc();
    host.send_word({8'h00, 3'h5, 17'h0, 4'h6});
    check(divider_select, 3'h0);
    w0(1'b0, 1'b0, 16'd60);
    check(divider_select, 3'h5);
    host.send_word({28'hfffffff, 4'h9});
    check(integer_divide, 16'd60);
    host.send_word(32'h00800025);
    check(fixed_reserved_word, 32'h00800025);
  endtask : t_misc
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_staging();
    t_phase();
    t_power();
    t_misc();
    complete_run();
  end
endmodule : tb
`default_nettype wire
